// ==== rtl/tpm_pkg.sv ====
// Package with register map, field layout and timing constants for the power datapath.
package tpm_pkg;
    // Register indexes on the plain register port.
    localparam logic [3:0] ADDR_MODE = 4'h0;
    localparam logic [3:0] ADDR_GAIN = 4'h1;
    localparam logic [3:0] ADDR_IRMS_OFS = 4'h2;
    localparam logic [3:0] ADDR_VRMS_OFS = 4'h3;
    localparam logic [3:0] ADDR_ACT_ENERGY = 4'h4;
    localparam logic [3:0] ADDR_APP_ENERGY = 4'h5;
    localparam logic [3:0] ADDR_IRMS = 4'h6;
    localparam logic [3:0] ADDR_VRMS = 4'h7;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h9;
    // Mode register fields: power mode in bits 1:0, phase select in bits 6:4.
    localparam int MODE_LSB = 0;
    localparam int SEL_LSB = 4;
    // Gain register bit that selects absolute-value summation.
    localparam int GAIN_ABS_BIT = 2;
    // Power modes.
    localparam logic [1:0] PM_WYE = 2'h0;
    localparam logic [1:0] PM_WYE2 = 2'h1;
    localparam logic [1:0] PM_DELTA4 = 2'h2;
    // Phase selections.
    localparam logic [2:0] SEL_ALL = 3'h0;
    localparam logic [2:0] SEL_AB = 3'h3;
    localparam logic [2:0] SEL_AC = 3'h5;
    localparam logic [2:0] SEL_BC = 3'h6;
    localparam logic [2:0] SEL_SEVEN = 3'h7;
    // Reset values.
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] GAIN_RST = 8'h00;
    localparam logic [15:0] OFS_RST = 16'h0000;
    localparam logic [2:0] MASK_RST = 3'h0;
    // Zero-crossing delay: 0.6 ms at 100 MHz.
    localparam int CLK_MHZ = 100;
    localparam int ZX_DELAY_US = 600;
    localparam int ZX_DELAY_CYC = ZX_DELAY_US * CLK_MHZ;
    // Filter shifts: current high-pass, rms low-pass and zero-crossing low-pass.
    localparam int HPF_SHIFT = 8;
    localparam int RMS_SHIFT = 10;
    localparam int ZX_SHIFT = 4;
endpackage : tpm_pkg

// ==== rtl/tpm_rms.sv ====
// One rms channel: optional high-pass, mean-square low-pass, root, signed offset.
`timescale 1ns/10ps
module tpm_rms #(
    parameter bit USE_HPF = 1'b0
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic smp_en_i,
    input wire logic signed [15:0] smp_i,
    input wire logic signed [15:0] ofs_i,
    output logic [23:0] rms_o
);
    logic signed [31:0] dc_reg;
    logic signed [16:0] ac;
    logic [33:0] ms_reg;
    logic [33:0] sq;
    logic [16:0] root;
    logic signed [24:0] sum;

    // High-pass removes dc only on the current path; voltage keeps its offset.
    always_comb begin
        if (USE_HPF) begin
            ac = 17'(smp_i) - 17'(dc_reg >>> tpm_pkg::HPF_SHIFT);
        end else begin
            ac = 17'(smp_i);
        end
        sq = 34'(ac * ac);
    end

    // Running dc estimate for the high-pass.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            dc_reg <= '0;
        end else if (smp_en_i && USE_HPF) begin
            dc_reg <= dc_reg + 32'(smp_i) - (dc_reg >>> tpm_pkg::HPF_SHIFT);
        end
    end

    // Mean-square low-pass; ripple at line and twice line remains.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ms_reg <= '0;
        end else if (smp_en_i) begin
            ms_reg <= ms_reg + (sq >> tpm_pkg::RMS_SHIFT) - (ms_reg >> tpm_pkg::RMS_SHIFT);
        end
    end

    // Bitwise integer square root of the mean square.
    always_comb begin
        logic [33:0] rem;
        logic [16:0] r;
        logic [33:0] trial;
        rem = ms_reg;
        r = '0;
        trial = '0;
        for (int b = 16; b >= 0; b--) begin
            trial = (34'(r) << (b + 1)) + (34'd1 << (2 * b));
            if (rem >= trial) begin
                rem = rem - trial;
                r = r | (17'd1 << b);
            end
        end
        root = r;
    end

    // Signed offset added to the root, result clipped at zero.
    always_comb begin
        sum = 25'(root) + 25'(ofs_i);
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rms_o <= '0;
        end else if (smp_en_i) begin
            rms_o <= sum[24] ? 24'h000000 : sum[23:0];
        end
    end
endmodule : tpm_rms

// ==== rtl/tpm_datapath.sv ====
// Three-phase active power, energy, rms and zero-crossing datapath.
`timescale 1ns/10ps
module tpm_datapath (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic smp_valid_i,
    input wire logic signed [15:0] va_i,
    input wire logic signed [15:0] vb_i,
    input wire logic signed [15:0] vc_i,
    input wire logic signed [15:0] ia_i,
    input wire logic signed [15:0] ib_i,
    input wire logic signed [15:0] ic_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic irq_o
);
    logic [7:0] mode_reg;
    logic [7:0] gain_reg;
    logic [15:0] irms_ofs_reg;
    logic [15:0] vrms_ofs_reg;
    logic [2:0] stat_reg;
    logic [2:0] mask_reg;
    logic [31:0] act_energy_reg;
    logic [31:0] app_energy_reg;
    logic signed [33:0] p1;
    logic signed [33:0] p2;
    logic signed [33:0] p3;
    logic signed [35:0] pwr;
    logic [33:0] mag1;
    logic [33:0] mag2;
    logic [23:0] irms;
    logic [23:0] vrms;
    logic [1:0] pmode;
    logic [2:0] psel;
    logic abs_sum;
    logic [2:0] zx_evt;

    assign pmode = mode_reg[tpm_pkg::MODE_LSB +: 2];
    assign psel = mode_reg[tpm_pkg::SEL_LSB +: 3];
    assign abs_sum = gain_reg[tpm_pkg::GAIN_ABS_BIT];

    // Per-phase products chosen by wiring mode and phase selection.
    always_comb begin
        p1 = '0;
        p2 = '0;
        p3 = '0;
        if (pmode == tpm_pkg::PM_WYE && psel == tpm_pkg::SEL_ALL) begin
            p1 = 34'(va_i * ia_i);
            p2 = 34'(vb_i * ib_i);
            p3 = 34'(vc_i * ic_i);
        end else if (pmode == tpm_pkg::PM_WYE2 && psel == tpm_pkg::SEL_SEVEN) begin
            p1 = 34'(va_i * (17'(ia_i) - 17'(ib_i)));
            p3 = 34'(vc_i * (17'(ic_i) - 17'(ib_i)));
        end else if (pmode == tpm_pkg::PM_DELTA4 && psel == tpm_pkg::SEL_SEVEN) begin
            p1 = 34'(va_i * (17'(ia_i) - 17'(ib_i)));
            p3 = 34'(vc_i * ic_i);
        end else if (pmode == tpm_pkg::PM_WYE) begin
            // Three-wire: neutral input is the reference phase, two products.
            if (psel == tpm_pkg::SEL_AB || psel == tpm_pkg::SEL_BC) begin
                p1 = 34'(va_i * ia_i);
                p2 = 34'(vb_i * ib_i);
            end else if (psel == tpm_pkg::SEL_AC) begin
                p1 = 34'(va_i * ia_i);
                p3 = 34'(vc_i * ic_i);
            end
        end
    end

    // Signed or absolute summation of the per-phase powers.
    always_comb begin
        if (abs_sum) begin
            pwr = 36'(p1[33] ? -p1 : p1) + 36'(p2[33] ? -p2 : p2)
                + 36'(p3[33] ? -p3 : p3);
        end else begin
            pwr = 36'(p1) + 36'(p2) + 36'(p3);
        end
    end

    // Apparent power magnitude uses the same scale as active power.
    always_comb begin
        mag1 = 34'(vrms[16:0]) * 34'(irms[16:0]);
        mag2 = mag1 >> 14;
    end

    // Energy accumulators updated on every sample.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            act_energy_reg <= '0;
            app_energy_reg <= '0;
        end else if (smp_valid_i) begin
            act_energy_reg <= act_energy_reg + 32'(pwr >>> 14);
            app_energy_reg <= app_energy_reg + 32'(mag2);
        end
    end

    // Current rms with high-pass, voltage rms without.
    tpm_rms #(.USE_HPF(1'b1)) u_irms (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .smp_en_i(smp_valid_i),
        .smp_i(ia_i),
        .ofs_i(irms_ofs_reg),
        .rms_o(irms)
    );

    tpm_rms #(.USE_HPF(1'b0)) u_vrms (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .smp_en_i(smp_valid_i),
        .smp_i(va_i),
        .ofs_i(vrms_ofs_reg),
        .rms_o(vrms)
    );

    // Zero-crossing detectors: low-passed voltage sign change, then delay.
    for (genvar g = 0; g < 3; g++) begin : g_zx
        logic signed [15:0] v;
        logic signed [19:0] lp_reg;
        logic sign_reg;
        logic pend_reg;
        logic [31:0] cnt_reg;
        assign v = (g == 0) ? va_i : ((g == 1) ? vb_i : vc_i);
        always_ff @(posedge core_clk_i) begin
            if (!rst_n_i) begin
                lp_reg <= '0;
                sign_reg <= 1'b0;
            end else if (smp_valid_i) begin
                lp_reg <= lp_reg + 20'(v) - (lp_reg >>> tpm_pkg::ZX_SHIFT);
                sign_reg <= lp_reg[19];
            end
        end
        // Delay counter shapes the fixed flag latency after the crossing.
        always_ff @(posedge core_clk_i) begin
            if (!rst_n_i) begin
                pend_reg <= 1'b0;
                cnt_reg <= '0;
            end else if (smp_valid_i && sign_reg && !lp_reg[19] && !pend_reg) begin
                pend_reg <= 1'b1;
                cnt_reg <= 32'(tpm_pkg::ZX_DELAY_CYC) - 32'd1;
            end else if (pend_reg) begin
                if (cnt_reg == 32'd0) begin
                    pend_reg <= 1'b0;
                end else begin
                    cnt_reg <= cnt_reg - 32'd1;
                end
            end
        end
        assign zx_evt[g] = pend_reg && (cnt_reg == 32'd0);
    end

    // Configuration registers written by the host.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            mode_reg <= tpm_pkg::MODE_RST;
            gain_reg <= tpm_pkg::GAIN_RST;
            irms_ofs_reg <= tpm_pkg::OFS_RST;
            vrms_ofs_reg <= tpm_pkg::OFS_RST;
            mask_reg <= tpm_pkg::MASK_RST;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                tpm_pkg::ADDR_MODE: mode_reg <= reg_wdata_i[7:0];
                tpm_pkg::ADDR_GAIN: gain_reg <= reg_wdata_i[7:0];
                tpm_pkg::ADDR_IRMS_OFS: irms_ofs_reg <= reg_wdata_i[15:0];
                tpm_pkg::ADDR_VRMS_OFS: vrms_ofs_reg <= reg_wdata_i[15:0];
                tpm_pkg::ADDR_IRQ_MASK: mask_reg <= reg_wdata_i[2:0];
                default: ;
            endcase
        end
    end

    // Sticky status; a new event wins over a write-one clear.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            stat_reg <= '0;
        end else begin
            stat_reg <= (stat_reg & ~((reg_wr_i && reg_addr_i == tpm_pkg::ADDR_IRQ_STAT)
                ? reg_wdata_i[2:0] : 3'h0)) | zx_evt;
        end
    end

    // Level interrupt from unmasked status.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(stat_reg & mask_reg);
        end
    end

    // Read data one cycle after the read strobe; zero otherwise.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                tpm_pkg::ADDR_MODE: reg_rdata_o <= {24'h000000, mode_reg};
                tpm_pkg::ADDR_GAIN: reg_rdata_o <= {24'h000000, gain_reg};
                tpm_pkg::ADDR_IRMS_OFS: reg_rdata_o <= {16'h0000, irms_ofs_reg};
                tpm_pkg::ADDR_VRMS_OFS: reg_rdata_o <= {16'h0000, vrms_ofs_reg};
                tpm_pkg::ADDR_ACT_ENERGY: reg_rdata_o <= act_energy_reg;
                tpm_pkg::ADDR_APP_ENERGY: reg_rdata_o <= app_energy_reg;
                tpm_pkg::ADDR_IRMS: reg_rdata_o <= {8'h00, irms};
                tpm_pkg::ADDR_VRMS: reg_rdata_o <= {8'h00, vrms};
                tpm_pkg::ADDR_IRQ_STAT: reg_rdata_o <= {29'h00000000, stat_reg};
                tpm_pkg::ADDR_IRQ_MASK: reg_rdata_o <= {29'h00000000, mask_reg};
                default: reg_rdata_o <= 32'h00000000;
            endcase
        end else begin
            reg_rdata_o <= 32'h00000000;
        end
    end
endmodule : tpm_datapath

// ==== testbench/tpm_host_model.sv ====
// Host model that drives the register port of the power datapath.
`timescale 1ns/10ps
module tpm_host_model (
    input wire logic core_clk_i,
    input wire logic [31:0] reg_rdata_i,
    output logic [3:0] reg_addr_o,
    output logic [31:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o
);
    // The bus is idle from time zero.
    initial begin
        reg_addr_o = 4'h0;
        reg_wdata_o = 32'h0;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end

    // One write cycle, then one idle cycle so strobes never collide.
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_o <= 1'b0;
        @(posedge core_clk_i);
    endtask : wr

    // One read cycle; the data stand only in the following cycle.
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_o <= 1'b0;
        @(posedge core_clk_i);
        d = reg_rdata_i;
    endtask : rd
endmodule : tpm_host_model

// ==== testbench/tpm_assertions.sv ====
// Checker for the register port and interrupt output of the power datapath.
`timescale 1ns/10ps
module tpm_checker (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic irq_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // Read data rest at zero outside the answer cycle.
    property p_rdata_idle;
        !reg_rd_i |=> reg_rdata_o == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    property p_unmapped;
        reg_rd_i && reg_addr_i > tpm_pkg::ADDR_IRQ_MASK |=> reg_rdata_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
    // Written configuration is read back unchanged.
    property p_mode_rb;
        logic [7:0] d;
        (reg_wr_i && reg_addr_i == tpm_pkg::ADDR_MODE, d = reg_wdata_i[7:0]) ##1 !reg_wr_i
            ##1 (reg_rd_i && reg_addr_i == tpm_pkg::ADDR_MODE)
            |=> (reg_rdata_o[7:0] & 8'h73) == (d & 8'h73);
    endproperty
    a_mode_rb: assert property (p_mode_rb) else $error("mode readback");
    property p_gain_rb;
        logic d;
        (reg_wr_i && reg_addr_i == tpm_pkg::ADDR_GAIN, d = reg_wdata_i[2]) ##1 !reg_wr_i
            ##1 (reg_rd_i && reg_addr_i == tpm_pkg::ADDR_GAIN) |=> reg_rdata_o[2] == d;
    endproperty
    a_gain_rb: assert property (p_gain_rb) else $error("gain readback");
    property p_ofs_rb;
        logic [15:0] d;
        (reg_wr_i && reg_addr_i == tpm_pkg::ADDR_IRMS_OFS, d = reg_wdata_i[15:0]) ##1 !reg_wr_i
            ##1 (reg_rd_i && reg_addr_i == tpm_pkg::ADDR_IRMS_OFS) |=> reg_rdata_o[15:0] == d;
    endproperty
    a_ofs_rb: assert property (p_ofs_rb) else $error("offset readback");
    // A mask write of zero silences the interrupt two cycles after the write.
    property p_mask_off;
        (reg_wr_i && reg_addr_i == tpm_pkg::ADDR_IRQ_MASK && reg_wdata_i[2:0] == 3'h0)
            ##1 !(reg_wr_i && reg_addr_i == tpm_pkg::ADDR_IRQ_MASK) |=> !irq_o;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("masked irq high");
    property p_stat_width;
        reg_rd_i && reg_addr_i == tpm_pkg::ADDR_IRQ_STAT |=> reg_rdata_o[31:3] == 29'h0;
    endproperty
    a_stat_width: assert property (p_stat_width) else $error("status upper bits");
    property p_rst_quiet;
        $rose(rst_n_i) |-> !irq_o && reg_rdata_o == 32'h0;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs after reset");
endmodule : tpm_checker

bind tpm_datapath tpm_checker u_tpm_checker (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .irq_o(irq_o)
);

// ==== testbench/three_phase_power_mode_datapath_tb.sv ====
// Self-checking bench for the three-phase power datapath.
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %0t got %h expected %h", $time, g, e); end end
module three_phase_power_mode_datapath_tb;
    localparam longint VA = -20000;
    localparam longint VB = -12000;
    localparam longint VC = -8000;
    localparam longint IA = 9000;
    localparam longint IB = -3000;
    localparam longint IC = 5000;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic smp_valid = 1'b0;
    logic signed [15:0] va = 16'(VA);
    logic signed [15:0] vb = 16'(VB);
    logic signed [15:0] vc = 16'(VC);
    logic signed [15:0] ia = 16'(IA);
    logic signed [15:0] ib = 16'(IB);
    logic signed [15:0] ic = 16'(IC);
    logic [3:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic wr;
    logic rd;
    logic irq;
    logic [31:0] d0;
    logic [31:0] d1;
    int n_errors = 0;
    int comparisons = 0;
    int cnt;

    tpm_datapath u_tpm_datapath (.core_clk_i(core_clk), .rst_n_i(rst_n),
        .smp_valid_i(smp_valid), .va_i(va), .vb_i(vb), .vc_i(vc), .ia_i(ia), .ib_i(ib),
        .ic_i(ic), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .irq_o(irq));
    tpm_host_model u_tpm_host_model (.core_clk_i(core_clk), .reg_rdata_i(rdata),
        .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));

    // The clock toggles every half period of 5 ns.
    always #5 core_clk = ~core_clk;

    // Prints the counts and the verdict, then stops the run.
    task automatic summarize;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    // Issues n samples, one every other cycle.
    task automatic smp(input int n);
        repeat (n) begin
            smp_valid <= 1'b1;
            @(posedge core_clk);
            smp_valid <= 1'b0;
            @(posedge core_clk);
        end
    endtask : smp

    // Checks the energy step of one sample in the given mode.
    task automatic pchk(input logic [1:0] m, input logic [2:0] s, input logic g, input longint p);
        logic [31:0] e0;
        logic [31:0] e1;
        u_tpm_host_model.wr(tpm_pkg::ADDR_GAIN, {29'h0, g, 2'h0});
        u_tpm_host_model.wr(tpm_pkg::ADDR_MODE, {25'h0, s, 2'h0, m});
        u_tpm_host_model.rd(tpm_pkg::ADDR_ACT_ENERGY, e0);
        smp(1);
        repeat (4) @(posedge core_clk);
        u_tpm_host_model.rd(tpm_pkg::ADDR_ACT_ENERGY, e1);
        `CHK(e1 - e0, 32'(p >>> 14))
    endtask : pchk

    // Main sequence: reset, registers, rms, power modes, zero crossing.
    initial begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        for (int a = 0; a < 16; a++) begin
            u_tpm_host_model.rd(4'(a), d0);
            `CHK(d0, 32'h0)
        end
        u_tpm_host_model.wr(4'hB, 32'hFFFF_FFFF);
        u_tpm_host_model.rd(4'hB, d0);
        `CHK(d0, 32'h0)
        // Long enough for the voltage mean square to settle on its exact fixed point.
        smp(16000);
        u_tpm_host_model.rd(tpm_pkg::ADDR_VRMS, d0);
        u_tpm_host_model.rd(tpm_pkg::ADDR_IRMS, d1);
        `CHK(d0 > 32'h3E8 && d1 < d0 / 4, 1'b1)
        `CHK(d0, 32'h0000_4E20)
        // The rms result only moves on a sample, so one follows each voltage offset write.
        u_tpm_host_model.wr(tpm_pkg::ADDR_VRMS_OFS, 32'h0000_FFFF);
        smp(1);
        u_tpm_host_model.rd(tpm_pkg::ADDR_VRMS, d1);
        `CHK(d1, d0 - 32'h1)
        u_tpm_host_model.wr(tpm_pkg::ADDR_VRMS_OFS, 32'h0000_F800);
        smp(1);
        u_tpm_host_model.rd(tpm_pkg::ADDR_VRMS, d1);
        `CHK(d1, d0 - 32'h800)
        u_tpm_host_model.wr(tpm_pkg::ADDR_IRMS_OFS, 32'h0000_F800);
        u_tpm_host_model.rd(tpm_pkg::ADDR_IRMS_OFS, d1);
        `CHK(d1[15:0], 16'hF800)
        pchk(2'h0, 3'h0, 1'b0, VA * IA + VB * IB + VC * IC);
        pchk(2'h1, 3'h7, 1'b0, VA * (IA - IB) + VC * (IC - IB));
        pchk(2'h0, 3'h3, 1'b0, VA * IA + VB * IB);
        pchk(2'h0, 3'h6, 1'b0, VA * IA + VB * IB);
        pchk(2'h0, 3'h5, 1'b0, VA * IA + VC * IC);
        pchk(2'h2, 3'h7, 1'b0, VA * (IA - IB) + VC * IC);
        pchk(2'h0, 3'h0, 1'b1, -VA * IA + VB * IB - VC * IC);
        pchk(2'h1, 3'h0, 1'b0, 0);
        u_tpm_host_model.wr(tpm_pkg::ADDR_MODE, 32'h73);
        u_tpm_host_model.rd(tpm_pkg::ADDR_MODE, d0);
        `CHK(d0 & 32'h73, 32'h73)
        u_tpm_host_model.wr(tpm_pkg::ADDR_GAIN, 32'h4);
        u_tpm_host_model.rd(tpm_pkg::ADDR_GAIN, d0);
        `CHK(d0[2], 1'b1)
        u_tpm_host_model.wr(tpm_pkg::ADDR_IRQ_MASK, 32'h7);
        va <= 16'(-VA);
        cnt = 0;
        while (irq !== 1'b1 && cnt < 70000) begin
            smp_valid <= ~smp_valid;
            @(posedge core_clk);
            cnt++;
        end
        smp_valid <= 1'b0;
        `CHK(cnt >= 60000 && cnt <= 60400, 1'b1)
        // A timed-out wait skips the interrupt checks and goes straight to the verdict.
        if (cnt < 70000) begin
            u_tpm_host_model.rd(tpm_pkg::ADDR_IRQ_STAT, d0);
            `CHK(d0, 32'h1)
            u_tpm_host_model.rd(tpm_pkg::ADDR_VRMS, d1);
            `CHK(d1 > 32'h0, 1'b1)
            u_tpm_host_model.wr(tpm_pkg::ADDR_IRQ_MASK, 32'h0);
            @(posedge core_clk);
            `CHK(irq, 1'b0)
            u_tpm_host_model.wr(tpm_pkg::ADDR_IRQ_MASK, 32'h1);
            @(posedge core_clk);
            `CHK(irq, 1'b1)
            u_tpm_host_model.wr(tpm_pkg::ADDR_IRQ_STAT, 32'h1);
            @(posedge core_clk);
            `CHK(irq, 1'b0)
        end
        summarize();
    end
endmodule : three_phase_power_mode_datapath_tb
